//--- src/drpd_pkg.sv
// Constants and types for the refresh and power-down state keeper.
// Assumes a single command clock mclk at 250 MHz and active-low async reset.
// Functional notes
// R1 - Refresh: CS RAS CAS low, CKE WE high
// R2 - Controller precharges all banks before refresh
// R3 - Refresh uses internal bank counter, ends idle
// R4 - Controller waits refresh cycle time after refresh
// R5 - At most eight posted, nine intervals gap
// R6 - Self refresh entry: CS RAS CAS CKE low
// R7 - Controller idles banks, termination off first
// R8 - Stay in self refresh while CKE low
// R9 - DLL off in self refresh, on after
// R10 - Internal refresh soon after entry; clock gated
// R11 - Controller may stop clock after entry
// R12 - Controller waits exit delays before commands
// R13 - Controller sends NOP during exit interval
// R14 - Extra refresh before re-entering self refresh
// R15 - No power-down during mode set or burst
// R16 - Idle banks: precharge, else active power-down
// R17 - DLL off except fast-exit active power-down
// R18 - Power-down keeps only clock, ODT, CKE buffers
// R19 - Controller bounds power-down duration
// R20 - Exit on CKE high with NOP or deselect
// R21 - Unexpected CKE drop: contents lost, reinitialise
// R22 - Frequency change only in precharge power-down
// R23 - Controller sends NOP during exit latency
package drpd_pkg;
    // ----------------------------------------------------------------
    // Geometry and timing
    // ----------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int BANK_W = 2;
    localparam int CLK_PERIOD_PS = 4000;
    // Internal refresh length in picoseconds; plain default
    localparam int REFRESH_CYCLE_TIME_PS = 105000;
    localparam int REFRESH_CYCLES = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] REFRESH_LEN = CNT_W'(REFRESH_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [BANK_W-1:0] BANK_ZERO = 2'h0;
    localparam logic [BANK_W-1:0] BANK_ONE = 2'h1;
    // Slow-exit select bit reset value (fast exit)
    localparam logic SLOW_EXIT_RST = 1'b0;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF, CMD_RW, CMD_MRS
    } drpd_cmd_e;

    typedef enum {
        ST_NORMAL, ST_PRE_PD, ST_ACT_PD, ST_SELF_REF, ST_LOST
    } drpd_state_e;
endpackage : drpd_pkg

//--- src/drpd_refresh_if.sv
// Request and status link between the state keeper and the refresh engine.
// Assumes both ends share mclk.
`timescale 1ns/10ps
interface drpd_refresh_if;
    import drpd_pkg::*;
    logic start; // One-cycle refresh request
    logic busy; // Refresh in progress
    logic [BANK_W-1:0] bank; // Bank being refreshed
    modport ctrl (output start, input busy, input bank);
    modport eng (input start, output busy, output bank);
endinterface : drpd_refresh_if

//--- src/drpd_refresh_engine.sv
// Internal refresh engine: walks its own bank counter for one refresh cycle.
// Requests that arrive while a refresh is in progress are dropped.
`timescale 1ns/10ps
module drpd_refresh_engine (
    input wire logic mclk, // Clock
    input wire logic resetn, // Async reset, active low
    drpd_refresh_if.eng rif // Request link
);
    import drpd_pkg::*;
    logic [CNT_W-1:0] cnt_q;
    logic [BANK_W-1:0] bank_q;

    // ----------------------------------------------------------------
    // Refresh timer and bank counter
    // ----------------------------------------------------------------
    // Bank address comes from this counter, never from the pins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= CNT_ZERO;
            bank_q <= BANK_ZERO;
        end else if (rif.start && cnt_q == CNT_ZERO) begin
            cnt_q <= REFRESH_LEN; // R3
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q <= cnt_q - CNT_ONE;
            bank_q <= bank_q + BANK_ONE; // R3
        end
    end
    assign rif.busy = (cnt_q != CNT_ZERO);
    assign rif.bank = bank_q;

    chk_busy_length: assert property (@(posedge mclk) disable iff (!resetn) // R3
        $rose(rif.busy) |-> rif.busy [*2])
        else $error("Refresh ended too early");
endmodule : drpd_refresh_engine

//--- src/drpd_top.sv
// DRAM refresh and low-power state keeper: decodes commands, tracks bank
// state, power-down and self refresh, DLL enable and buffer enable.
// Assumes command pins are synchronous to mclk; ck_n pairs with it externally.
`timescale 1ns/10ps
module drpd_top (
    input wire logic mclk, // Command clock
    input wire logic resetn, // Async reset, active low
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Chip select, low active
    input wire logic ras_n, // Row strobe, low active
    input wire logic cas_n, // Column strobe, low active
    input wire logic we_n, // Write enable, low active
    input wire logic [drpd_pkg::BANK_W-1:0] ba, // Bank address
    input wire logic a10, // Precharge-all select
    input wire logic slow_exit, // Active power-down slow exit mode
    output logic [drpd_pkg::NUM_BANKS-1:0] bank_open, // Open-bank map
    output logic dll_en, // DLL running
    output logic buf_en, // Command/data input buffers on
    output logic clk_gate_en, // Internal clock running
    output logic refreshing, // Internal refresh in progress
    output logic [drpd_pkg::BANK_W-1:0] refresh_bank, // Internal refresh bank
    output logic self_refresh, // In self refresh
    output logic power_down, // In either power-down
    output logic active_pd, // In active power-down
    output logic contents_lost // Array contents no longer trusted
);
    import drpd_pkg::*;

    drpd_refresh_if rif ();
    drpd_state_e state_q;
    drpd_cmd_e cmd;
    logic cke_q;
    logic [NUM_BANKS-1:0] open_q;
    logic sr_req_q;
    logic lost_q;
    logic dll_q;
    logic pd_slow_q;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    function automatic drpd_cmd_e decode(input logic c, input logic r,
                                         input logic ca, input logic w, input logic a);
        if (c || (r && ca && w)) return CMD_NOP;
        if (r) return CMD_RW;
        if (ca) return w ? CMD_ACT : (a ? CMD_PREA : CMD_PRE);
        return w ? CMD_REF : CMD_MRS; // R1 R6
    endfunction : decode

    always_comb begin
        cmd = decode(cs_n, ras_n, cas_n, we_n, a10);
    end

    // Previous CKE distinguishes a fresh command from a held state
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) cke_q <= 1'b1;
        else cke_q <= cke;
    end

    // ----------------------------------------------------------------
    // Refresh engine
    // ----------------------------------------------------------------
    // Auto refresh: CKE high now and before, refresh code on the pins
    logic auto_ref;
    logic sr_entry;
    assign auto_ref = (state_q == ST_NORMAL) && cke_q && cke && cmd == CMD_REF; // R1
    assign sr_entry = (state_q == ST_NORMAL) && cke_q && !cke && cmd == CMD_REF; // R6
    // Self refresh needs one internal refresh right after entry
    assign rif.start = auto_ref || sr_req_q; // R10

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) sr_req_q <= 1'b0;
        else sr_req_q <= sr_entry; // R10
    end

    drpd_refresh_engine u_eng (
        .mclk(mclk),
        .resetn(resetn),
        .rif(rif)
    );

    // ----------------------------------------------------------------
    // Bank state
    // ----------------------------------------------------------------
    // Only activate, precharge and refresh matter here; bursts are another block's
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            open_q <= '0;
        end else if (state_q == ST_NORMAL && cke_q && cke) begin
            unique case (cmd)
                CMD_ACT: open_q[ba] <= 1'b1;
                CMD_PRE: open_q[ba] <= 1'b0;
                CMD_PREA: open_q <= '0;
                CMD_REF: open_q <= '0; // R3
                CMD_NOP, CMD_RW, CMD_MRS: open_q <= open_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    // CKE falling without the refresh code is power-down; the bank map
    // picks the flavour. Exit needs CKE high with NOP or deselect.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_NORMAL;
            pd_slow_q <= SLOW_EXIT_RST;
        end else begin
            unique case (state_q)
                ST_NORMAL: begin
                    if (sr_entry) state_q <= ST_SELF_REF; // R6
                    else if (cke_q && !cke) begin
                        pd_slow_q <= slow_exit;
                        if (open_q == '0) state_q <= ST_PRE_PD; // R16
                        else state_q <= ST_ACT_PD; // R16
                    end
                end
                ST_PRE_PD, ST_ACT_PD: begin
                    if (cke && cmd == CMD_NOP) state_q <= ST_NORMAL; // R20
                end
                ST_SELF_REF: begin
                    if (cke) state_q <= ST_NORMAL; // R8
                end
                ST_LOST: state_q <= ST_LOST;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Contents-lost flag
    // ----------------------------------------------------------------
    // CKE may fall during activate, precharge or refresh; a mode set or a
    // burst on the pins at the falling edge is the drop that breaks the array.
    // Bursts already under way are another block's, so they go unseen here.
    logic bad_drop;
    assign bad_drop = (state_q == ST_NORMAL) && cke_q && !cke
                      && (cmd == CMD_MRS || cmd == CMD_RW); // R21
    // Sticky; only reset, the start of full re-initialisation, clears it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) lost_q <= 1'b0;
        else if (bad_drop) lost_q <= 1'b1; // R21
    end

    // ----------------------------------------------------------------
    // DLL enable
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) dll_q <= 1'b1;
        else begin
            unique case (state_q)
                ST_SELF_REF: dll_q <= 1'b0; // R9
                ST_PRE_PD: dll_q <= 1'b0; // R17
                ST_ACT_PD: dll_q <= !pd_slow_q; // R17
                ST_NORMAL, ST_LOST: dll_q <= 1'b1; // R9
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bank_open = open_q;
    assign dll_en = dll_q;
    assign self_refresh = (state_q == ST_SELF_REF);
    assign power_down = (state_q == ST_PRE_PD) || (state_q == ST_ACT_PD);
    assign active_pd = (state_q == ST_ACT_PD);
    assign buf_en = !(power_down || self_refresh); // R18
    // Clock runs only while the engine needs it inside self refresh
    assign clk_gate_en = !self_refresh || rif.busy || sr_req_q; // R10
    assign refreshing = rif.busy;
    assign refresh_bank = rif.bank;
    assign contents_lost = lost_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_ref_starts: assert property (@(posedge mclk) disable iff (!resetn) // R1
        (auto_ref && !rif.busy) |=> rif.busy)
        else $error("Auto refresh did not start");
    chk_ref_closes: assert property (@(posedge mclk) disable iff (!resetn) // R3
        auto_ref |=> open_q == '0)
        else $error("Banks left open after refresh");
    chk_sr_enter: assert property (@(posedge mclk) disable iff (!resetn) // R6
        sr_entry |=> self_refresh ##1 (refreshing || !self_refresh))
        else $error("Self refresh entry missed");
    chk_sr_hold: assert property (@(posedge mclk) disable iff (!resetn) // R8
        (self_refresh && !cke) |=> self_refresh)
        else $error("Self refresh left with CKE low");
    chk_dll_sr: assert property (@(posedge mclk) disable iff (!resetn) // R9
        (self_refresh && $past(self_refresh)) |-> !dll_en)
        else $error("DLL running in self refresh");
    chk_pd_kind: assert property (@(posedge mclk) disable iff (!resetn) // R16
        (state_q == ST_NORMAL && cke_q && !cke && !sr_entry && open_q != '0)
        |=> active_pd)
        else $error("Wrong power-down kind");
    chk_dll_pd: assert property (@(posedge mclk) disable iff (!resetn) // R17
        (state_q == ST_PRE_PD) |=> (state_q != ST_PRE_PD || !dll_en))
        else $error("DLL running in precharge power-down");
    chk_buf_pd: assert property (@(posedge mclk) disable iff (!resetn) // R18
        (state_q == ST_NORMAL && cke_q && !cke) |=> !buf_en)
        else $error("Buffers on after CKE fell");
    chk_pd_exit: assert property (@(posedge mclk) disable iff (!resetn) // R20
        (power_down && cke && cmd == CMD_NOP) |=> !power_down)
        else $error("Power-down exit missed");
    chk_exit_refused: assert property (@(posedge mclk) disable iff (!resetn) // R20
        (power_down && cke && cmd != CMD_NOP) |=> power_down)
        else $error("Power-down left without NOP");
    chk_pd_pre: assert property (@(posedge mclk) disable iff (!resetn) // R16
        (state_q == ST_NORMAL && cke_q && !cke && !sr_entry && open_q == '0)
        |=> (power_down && !active_pd))
        else $error("Wrong power-down kind for idle banks");
    chk_dll_fast: assert property (@(posedge mclk) disable iff (!resetn) // R17
        (active_pd && $past(active_pd) && !pd_slow_q) |-> dll_en)
        else $error("DLL stopped in fast-exit active power-down");
    chk_sr_exit: assert property (@(posedge mclk) disable iff (!resetn) // R9
        (self_refresh && cke) |=> !self_refresh ##1 dll_en)
        else $error("DLL not back after self refresh exit");
    chk_lost_burst: assert property (@(posedge mclk) disable iff (!resetn) // R21
        bad_drop |=> contents_lost)
        else $error("Bad CKE drop not flagged");
    chk_lost_sticky: assert property (@(posedge mclk) disable iff (!resetn) // R21
        contents_lost |=> contents_lost)
        else $error("Contents-lost flag cleared without reset");
endmodule : drpd_top

//--- tb/drpd_ctrl_model.sv
// Controller-side model: turns a requested command into command pin levels.
// Assumes requests change by non-blocking assignment at a rising mclk edge.
`timescale 1ns/10ps
module drpd_ctrl_model (
    mclk, // Command clock
    req, // Requested command
    req_cke, // Requested clock enable level
    req_bank, // Requested bank
    cke, // Clock enable pin
    cs_n, // Chip select pin
    ras_n, // Row strobe pin
    cas_n, // Column strobe pin
    we_n, // Write enable pin
    ba, // Bank address pins
    a10 // Precharge-all pin
);
    import drpd_pkg::*;
    input wire logic mclk;
    input wire drpd_pkg::drpd_cmd_e req;
    input wire logic req_cke;
    input wire logic [drpd_pkg::BANK_W-1:0] req_bank;
    output logic cke, cs_n, ras_n, cas_n, we_n, a10;
    output logic [drpd_pkg::BANK_W-1:0] ba;
    logic flip_q = 1'b0;

    // Don't-care address lines wander every cycle so stale values never help
    always_ff @(posedge mclk) begin
        flip_q <= ~flip_q;
    end

    // Pin encoder; no spacing or bank checks here, and the bench also drives illegal requests on purpose
    always_comb begin
        {cs_n, ras_n, cas_n, we_n} = 4'h7; // NOP fills exit intervals
        ba = {BANK_W{flip_q}};
        a10 = ~flip_q;
        cke = req_cke;
        case (req)
            CMD_ACT: begin
                {cs_n, ras_n, cas_n, we_n} = 4'h3;
                ba = req_bank;
            end
            CMD_PRE, CMD_PREA: begin
                {cs_n, ras_n, cas_n, we_n} = 4'h2;
                ba = req_bank;
                a10 = (req == CMD_PREA);
            end
            CMD_REF: {cs_n, ras_n, cas_n, we_n} = 4'h1;
            CMD_MRS: {cs_n, ras_n, cas_n, we_n} = 4'h0;
            CMD_RW: {cs_n, ras_n, cas_n, we_n} = 4'h5;
            default: ;
        endcase
    end
endmodule : drpd_ctrl_model

//--- tb/test_dram_refresh_power_down.sv
// Self-checking bench: row table for bank and power-down cases, then refresh,
// self refresh and CKE-drop tests. Assumes the package defaults for timing.
`timescale 1ns/10ps
module test_dram_refresh_power_down;
    import drpd_pkg::*;
    typedef struct {
        drpd_cmd_e c; logic k; logic [1:0] b; logic s; logic [3:0] bo; logic [3:0] st;
    } drpd_row_s;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic slow_exit = 1'b0;
    drpd_cmd_e req = CMD_NOP;
    logic req_cke = 1'b1;
    logic [1:0] req_bank = 2'h0;
    logic cke, cs_n, ras_n, cas_n, we_n, a10, dll_en, buf_en, clk_gate_en;
    logic refreshing, self_refresh, power_down, active_pd, contents_lost;
    logic [1:0] ba, refresh_bank;
    logic [3:0] bank_open;
    int failures = 0;
    int n_checks = 0;
    int len;
    // Rows: command, cke, bank, slow exit, open map, {pd, active pd, dll, buffers}
    drpd_row_s rows [12] = '{
        '{CMD_ACT, 1, 0, 0, 4'h1, 4'h3}, '{CMD_ACT, 1, 2, 0, 4'h5, 4'h3},
        '{CMD_PRE, 1, 0, 0, 4'h4, 4'h3}, '{CMD_NOP, 0, 0, 0, 4'h4, 4'he},
        '{CMD_NOP, 1, 0, 0, 4'h4, 4'h3}, '{CMD_PREA, 1, 0, 0, 4'h0, 4'h3},
        '{CMD_NOP, 0, 0, 0, 4'h0, 4'h8}, '{CMD_NOP, 1, 0, 0, 4'h0, 4'h3},
        '{CMD_ACT, 1, 1, 0, 4'h2, 4'h3}, '{CMD_NOP, 0, 0, 1, 4'h2, 4'hc},
        '{CMD_NOP, 1, 0, 1, 4'h2, 4'h3}, '{CMD_PREA, 1, 0, 0, 4'h0, 4'h3}};

    initial begin
        forever #2 mclk = ~mclk;
    end

    drpd_ctrl_model i_ctrl (.mclk(mclk), .req(req), .req_cke(req_cke), .req_bank(req_bank),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10));
    drpd_top i_dut (.mclk(mclk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10), .slow_exit(slow_exit),
        .bank_open(bank_open), .dll_en(dll_en), .buf_en(buf_en), .clk_gate_en(clk_gate_en),
        .refreshing(refreshing), .refresh_bank(refresh_bank), .self_refresh(self_refresh),
        .power_down(power_down), .active_pd(active_pd), .contents_lost(contents_lost));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk_bit
    task chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : chk_val
    // Present one command after an edge; returns at the edge that takes it
    task step(input drpd_cmd_e c, input logic k, input logic [1:0] b);
        req <= c;
        req_cke <= k;
        req_bank <= b;
        @(posedge mclk);
    endtask : step
    // Measures how long the engine stays busy; can re-request mid-refresh
    task busy_len(input bit poke, output int n);
        n = 0;
        for (int i = 0; i < 4 && refreshing !== 1'b1; i++) @(posedge mclk);
        while (refreshing === 1'b1 && n < 60) begin
            req <= (poke && n == 5) ? CMD_REF : CMD_NOP;
            n++;
            @(posedge mclk);
        end
        req <= CMD_NOP;
    endtask : busy_len
    task complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // Watchdog sized well beyond the roughly 160 cycles the tests need;
    // the whole run is far inside one refresh interval
    initial begin
        repeat (5000) @(posedge mclk);
        failures++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        chk_val({bank_open, dll_en, buf_en, clk_gate_en, refreshing}, 8'h0e, "reset outputs");
        chk_val({self_refresh, power_down, active_pd, contents_lost}, 8'h00, "reset states");
        resetn <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) begin
            slow_exit <= rows[i].s;
            step(rows[i].c, rows[i].k, rows[i].b);
            repeat (3) step(CMD_NOP, rows[i].k, 2'h0);
            #1;
            chk_val(8'(bank_open), 8'(rows[i].bo), "bank map");
            chk_val(8'({power_down, active_pd, dll_en, buf_en}), 8'(rows[i].st),
                "power-down state");
        end
        $display("table rows done");
        // Refresh ignores the address bus; a second request while busy is dropped
        step(CMD_REF, 1'b1, 2'h3);
        busy_len(1'b1, len);
        chk_val(8'(len), REFRESH_LEN, "refresh length");
        chk_val(8'(bank_open), 8'h00, "banks idle after refresh");
        chk_val(8'(refresh_bank), 8'(REFRESH_CYCLES % NUM_BANKS), "bank counter walked");
        $display("auto refresh done");
        // Self refresh with junk commands on the bus while CKE is low
        step(CMD_REF, 1'b0, 2'h0);
        step(CMD_ACT, 1'b0, 2'h1);
        busy_len(1'b1, len);
        #1;
        chk_val(8'(len), REFRESH_LEN, "internal refresh length");
        chk_val({self_refresh, dll_en, buf_en, refreshing}, 8'h08, "self refresh entry");
        chk_bit(clk_gate_en, 1'b0, "clock gated in self refresh");
        chk_val({self_refresh, bank_open}, 8'h10, "activates ignored");
        repeat (3) step(CMD_NOP, 1'b1, 2'h0);
        #1;
        chk_val({self_refresh, dll_en, buf_en, clk_gate_en}, 8'h07, "self refresh exit");
        $display("self refresh done");
        // Idle stands in for both exit delays; no re-entry, so no extra refresh is owed
        repeat (REFRESH_CYCLES) step(CMD_NOP, 1'b1, 2'h0);
        // CKE may fall during a refresh: plain power-down, contents kept
        step(CMD_REF, 1'b1, 2'h0);
        repeat (4) step(CMD_NOP, 1'b0, 2'h0);
        #1;
        chk_val({power_down, active_pd, contents_lost, refreshing}, 8'h09, "pd in refresh");
        step(CMD_ACT, 1'b1, 2'h1);
        #1;
        chk_val({power_down, bank_open}, 8'h10, "exit refused without NOP");
        repeat (3) step(CMD_NOP, 1'b1, 2'h0);
        #1;
        chk_val({power_down, dll_en, buf_en, contents_lost}, 8'h06, "exit after refresh");
        $display("refresh power-down done");
        // CKE falls with a mode set on the pins: contents no longer trusted
        step(CMD_MRS, 1'b0, 2'h0);
        repeat (3) step(CMD_NOP, 1'b0, 2'h0);
        #1;
        chk_bit(contents_lost, 1'b1, "contents lost flag");
        resetn <= 1'b0;
        req_cke <= 1'b1;
        @(posedge mclk);
        #1;
        chk_bit(contents_lost, 1'b0, "flag cleared by reset");
        // Second release: the first command lands on the first edge after it
        @(posedge mclk);
        resetn <= 1'b1;
        step(CMD_ACT, 1'b1, 2'h3);
        step(CMD_NOP, 1'b1, 2'h0);
        #1;
        chk_val({bank_open, dll_en, buf_en, clk_gate_en, refreshing}, 8'h8e, "outputs after reset");
        chk_val({self_refresh, power_down, active_pd, contents_lost}, 8'h00, "states after reset");
        $display("cke drop done");
        complete_run();
    end
endmodule : test_dram_refresh_power_down
